// ### hdl/stc_defs.svh
// Constants for the serial time code generator
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define STC_CLK_MHZ 100
`define STC_CYC_PER_MS (`STC_CLK_MHZ * 1000)
`define STC_BIT_MS 10
`define STC_ZERO_MS 2
`define STC_ONE_MS 5
`define STC_MARK_MS 8
`define STC_SHORT_SCALE 4
`define STC_CARRIER_KHZ 1000
`define STC_PHASE_STEP (64'h1_0000_0000 * `STC_CARRIER_KHZ / `STC_CYC_PER_MS)
`define STC_LONG_LEN 7'h64
`define STC_SHORT_LEN 7'h19
`define STC_LEAP_WARN 17'h0003B
`define STC_SAV_WARN 17'h00001
`define STC_OFS_CTRL 8'h00
`define STC_OFS_TIME 8'h04
`define STC_OFS_ZONE 8'h08
`define STC_OFS_LEAP 8'h0C
`define STC_OFS_SAV 8'h10
`define STC_OFS_STAT 8'h14
`define STC_CTRL_RST 7'h08
`define STC_F_AM 3
`define STC_F_ARM 31
`define STC_F_DIR 24
`define STC_F_DACT 25
`define STC_P_SEC 1
`define STC_P_MIN 10
`define STC_P_HOUR 20
`define STC_P_DAY 30
`define STC_P_DAYH 40
`define STC_S_SEC 1
`define STC_S_MIN 8
`define STC_S_HOUR 15
`define STC_P_YEAR 50
`define STC_P_LEAP 60
`define STC_P_SAV 62
`define STC_P_OFS 64
`define STC_P_HALF 70
`define STC_P_QUAL 71
`define STC_P_PAR 75
`define STC_P_DSEC 80
`define STC_P_DSECH 90
`define STC_Q_LOCKED 4'h0
`define STC_Q_BASE 4'h4
`define STC_Q_WORST 4'h9
`define STC_Q_UNREL 4'hF
`endif

// ### hdl/stc_gen.sv
// Serial time code generator with APB registers
`include "stc_defs.svh"
module stc_gen
   import stc_pkg::*;
#(
   parameter int BIT_CYC = `STC_BIT_MS * `STC_CYC_PER_MS,
   parameter int ZERO_CYC = `STC_ZERO_MS * `STC_CYC_PER_MS,
   parameter int ONE_CYC = `STC_ONE_MS * `STC_CYC_PER_MS,
   parameter int MARK_CYC = `STC_MARK_MS * `STC_CYC_PER_MS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pps_in,
   input wire logic ref_locked,
   input wire logic [2:0] err_class,
   output logic [7:0] am_out,
   output logic [2:0] lvl_out
);
   localparam int SC = `STC_SHORT_SCALE;
   localparam logic [23:0] L_BIT = 24'(BIT_CYC);
   localparam logic [23:0] L_BIT_S = 24'(BIT_CYC * SC);
   localparam logic [23:0] L_ZERO = 24'(ZERO_CYC);
   localparam logic [23:0] L_ONE = 24'(ONE_CYC);
   localparam logic [23:0] L_MARK = 24'(MARK_CYC);
   localparam logic [31:0] STEP = 32'(`STC_PHASE_STEP);

   logic [6:0] ctrl_ff;
   logic [25:0] time_ff;
   logic [14:0] zone_ff;
   logic [16:0] leap_cnt_ff;
   logic leap_arm_ff;
   logic leap_del_ff;
   logic [16:0] sav_cnt_ff;
   logic sav_arm_ff;
   logic sav_new_ff;
   logic sav_act_ff;
   logic ever_ff;
   logic pps_s1_ff, pps_s2_ff, pps_s3_ff;
   logic pps_rise;
   stc_state_e state_ff;
   logic [99:0] data_ff, mark_ff;
   logic short_ff;
   logic [6:0] idx_ff;
   logic [23:0] cyc_ff;
   logic pulse_ff;
   logic [31:0] phase_ff;
   logic [31:0] prdata_ff;
   logic [7:0] am_ff;
   logic [2:0] lvl_ff;
   logic [99:0] nxt_data, nxt_mark;
   logic [3:0] qual;
   logic [16:0] day_secs;
   logic [7:0] bsec, bmin, bhour, byear;
   logic [11:0] bday;
   logic [31:0] rdata;
   logic hit, wr, rd_setup;
   logic [23:0] width, bit_len;
   logic leap_pend, sav_pend;
   logic [7:0] sine;
   stc_fmt_e fmt;

   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      to_bcd = {4'(v / 7'd10), 4'(v % 7'd10)};
   endfunction : to_bcd

   function automatic logic [7:0] sine_lut(input logic [3:0] p);
      unique case (p)
         4'h0: sine_lut = 8'h00;
         4'h1: sine_lut = 8'h31;
         4'h2: sine_lut = 8'h5A;
         4'h3: sine_lut = 8'h75;
         4'h4: sine_lut = 8'h7F;
         4'h5: sine_lut = 8'h75;
         4'h6: sine_lut = 8'h5A;
         4'h7: sine_lut = 8'h31;
         4'h8: sine_lut = 8'h00;
         4'h9: sine_lut = 8'hCF;
         4'hA: sine_lut = 8'hA6;
         4'hB: sine_lut = 8'h8B;
         4'hC: sine_lut = 8'h81;
         4'hD: sine_lut = 8'h8B;
         4'hE: sine_lut = 8'hA6;
         4'hF: sine_lut = 8'hCF;
      endcase
   endfunction : sine_lut

   ////////////////////////////////////////////////////////////////////////
   // APB slave
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign hit = paddr == `STC_OFS_CTRL || paddr == `STC_OFS_TIME
             || paddr == `STC_OFS_ZONE || paddr == `STC_OFS_LEAP
             || paddr == `STC_OFS_SAV || paddr == `STC_OFS_STAT;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_ff;

   always_comb
   begin
      unique case (paddr)
         `STC_OFS_CTRL: rdata = {25'h0, ctrl_ff};
         `STC_OFS_TIME: rdata = {6'h0, time_ff};
         `STC_OFS_ZONE: rdata = {17'h0, zone_ff};
         `STC_OFS_LEAP: rdata = {leap_arm_ff, 6'h0, leap_del_ff, 7'h0, leap_cnt_ff};
         `STC_OFS_SAV: rdata = {sav_arm_ff, 5'h0, sav_act_ff, sav_new_ff, 7'h0, sav_cnt_ff};
         `STC_OFS_STAT: rdata = {15'h0, ever_ff, qual, 3'h0, state_ff == STC_SEND, 1'b0, idx_ff};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         prdata_ff <= 32'h0000_0000;
      else if (rd_setup)
         prdata_ff <= rdata;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_ff <= `STC_CTRL_RST;
      else if (wr && paddr == `STC_OFS_CTRL)
         ctrl_ff <= pwdata[6:0];
   end
   assign fmt = stc_fmt_e'(ctrl_ff[2:0]);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         time_ff <= 26'h0;
         zone_ff <= 15'h0;
      end
      else if (wr && paddr == `STC_OFS_TIME)
         time_ff <= pwdata[25:0];
      else if (wr && paddr == `STC_OFS_ZONE)
         zone_ff <= pwdata[14:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Leap and daylight-saving countdowns, one step per epoch
   // leap countdown
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         leap_cnt_ff <= 17'h0;
         leap_arm_ff <= 1'b0;
         leap_del_ff <= 1'b0;
      end
      else if (wr && paddr == `STC_OFS_LEAP)
      begin
         leap_cnt_ff <= pwdata[16:0];
         leap_del_ff <= pwdata[`STC_F_DIR];
         leap_arm_ff <= pwdata[`STC_F_ARM];
      end
      else if (pps_rise && leap_arm_ff)
      begin
         if (leap_cnt_ff == 17'h0)
            leap_arm_ff <= 1'b0;
         else
            leap_cnt_ff <= leap_cnt_ff - 17'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sav_cnt_ff <= 17'h0;
         sav_arm_ff <= 1'b0;
         sav_new_ff <= 1'b0;
         sav_act_ff <= 1'b0;
      end
      else if (wr && paddr == `STC_OFS_SAV)
      begin
         sav_cnt_ff <= pwdata[16:0];
         sav_new_ff <= pwdata[`STC_F_DIR];
         sav_act_ff <= pwdata[`STC_F_DACT];
         sav_arm_ff <= pwdata[`STC_F_ARM];
      end
      else if (pps_rise && sav_arm_ff)
      begin
         if (sav_cnt_ff == 17'h0)
         begin
            sav_arm_ff <= 1'b0;
            sav_act_ff <= sav_new_ff;
         end
         else
            sav_cnt_ff <= sav_cnt_ff - 17'h1;
      end
   end
   assign leap_pend = leap_arm_ff && leap_cnt_ff <= `STC_LEAP_WARN;
   assign sav_pend = sav_arm_ff && sav_cnt_ff == `STC_SAV_WARN;

   ////////////////////////////////////////////////////////////////////////
   // Time quality
   always_ff @(posedge clk)
   begin
      if (rst)
         ever_ff <= 1'b0;
      else if (ref_locked)
         ever_ff <= 1'b1;
   end

   always_comb
   begin
      if (!ever_ff)
         qual = `STC_Q_UNREL;
      else if (ref_locked)
         qual = `STC_Q_LOCKED;
      else if (err_class > 3'h5)
         qual = `STC_Q_WORST;
      else
         qual = `STC_Q_BASE + {1'b0, err_class};
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame builder
   assign bsec = to_bcd(time_ff[6:0] & 7'h3F);
   assign bmin = to_bcd({1'b0, time_ff[11:6]});
   assign bhour = to_bcd({2'b0, time_ff[16:12]});
   assign bday = {4'(time_ff[25:17] / 9'd100),
                  4'((time_ff[25:17] % 9'd100) / 9'd10),
                  4'(time_ff[25:17] % 9'd10)};
   assign byear = to_bcd(zone_ff[6:0]);
   assign day_secs = 17'(time_ff[16:12]) * 17'd3600 + 17'(time_ff[11:6]) * 17'd60
                   + 17'(time_ff[5:0]);

   always_comb
   begin
      nxt_data = '0;
      nxt_mark = '0;
      nxt_mark[0] = 1'b1;
      if (fmt == STC_FMT_W25)
      begin
         nxt_data[`STC_S_SEC +: 4] = bsec[3:0];
         nxt_data[`STC_S_SEC + 4 +: 3] = bsec[6:4];
         nxt_data[`STC_S_MIN +: 4] = bmin[3:0];
         nxt_data[`STC_S_MIN + 4 +: 3] = bmin[6:4];
         nxt_data[`STC_S_HOUR +: 4] = bhour[3:0];
         nxt_data[`STC_S_HOUR + 4 +: 2] = bhour[5:4];
      end
      else
      begin
         for (int k = 9; k < 100; k += 10)
            nxt_mark[k] = 1'b1;
         nxt_data[`STC_P_SEC +: 4] = bsec[3:0];
         nxt_data[`STC_P_SEC + 5 +: 3] = bsec[6:4];
         nxt_data[`STC_P_MIN +: 4] = bmin[3:0];
         nxt_data[`STC_P_MIN + 5 +: 3] = bmin[6:4];
         nxt_data[`STC_P_HOUR +: 4] = bhour[3:0];
         nxt_data[`STC_P_HOUR + 5 +: 2] = bhour[5:4];
         nxt_data[`STC_P_DAY +: 4] = bday[3:0];
         nxt_data[`STC_P_DAY + 5 +: 4] = bday[7:4];
         nxt_data[`STC_P_DAYH +: 2] = bday[9:8];
      end
      if (fmt == STC_FMT_BINSEC || fmt == STC_FMT_STATUS)
      begin
         nxt_data[`STC_P_DSEC +: 9] = day_secs[8:0];
         nxt_data[`STC_P_DSECH +: 8] = day_secs[16:9];
      end
      if (fmt == STC_FMT_STATUS)
      begin
         nxt_data[`STC_P_YEAR +: 4] = byear[3:0];
         nxt_data[`STC_P_YEAR + 5 +: 4] = byear[7:4];
         nxt_data[`STC_P_LEAP] = leap_pend;
         nxt_data[`STC_P_LEAP + 1] = leap_arm_ff && leap_del_ff;
         nxt_data[`STC_P_SAV] = sav_pend;
         nxt_data[`STC_P_SAV + 1] = sav_act_ff;
         nxt_data[`STC_P_OFS] = zone_ff[8];
         nxt_data[`STC_P_OFS + 1 +: 4] = zone_ff[12:9];
         nxt_data[`STC_P_HALF] = zone_ff[13];
         nxt_data[`STC_P_QUAL +: 4] = qual;
         nxt_data[`STC_P_PAR] = ~^nxt_data[`STC_P_PAR - 1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Epoch input and frame sequencer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pps_s1_ff <= 1'b0;
         pps_s2_ff <= 1'b0;
         pps_s3_ff <= 1'b0;
      end
      else
      begin
         pps_s1_ff <= pps_in;
         pps_s2_ff <= pps_s1_ff;
         pps_s3_ff <= pps_s2_ff;
      end
   end
   assign pps_rise = pps_s2_ff && !pps_s3_ff;

   assign bit_len = short_ff ? L_BIT_S : L_BIT;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= STC_IDLE;
         data_ff <= '0;
         mark_ff <= '0;
         short_ff <= 1'b0;
         idx_ff <= 7'h0;
         cyc_ff <= 24'h0;
      end
      else if (pps_rise)
      begin
         state_ff <= STC_SEND;
         data_ff <= nxt_data;
         mark_ff <= nxt_mark;
         short_ff <= fmt == STC_FMT_W25;
         idx_ff <= 7'h0;
         cyc_ff <= 24'h0;
      end
      else
      begin
         unique case (state_ff)
            STC_IDLE:
               cyc_ff <= 24'h0;
            STC_SEND:
               if (cyc_ff == bit_len - 24'h1)
               begin
                  cyc_ff <= 24'h0;
                  idx_ff <= idx_ff + 7'h1;
                  if (idx_ff == (short_ff ? `STC_SHORT_LEN : `STC_LONG_LEN) - 7'h1)
                     state_ff <= STC_IDLE;
               end
               else
                  cyc_ff <= cyc_ff + 24'h1;
         endcase
      end
   end

   always_comb
   begin
      if (mark_ff[idx_ff])
         width = L_MARK;
      else if (data_ff[idx_ff])
         width = L_ONE;
      else
         width = L_ZERO;
      if (short_ff)
         width = 24'(width * 24'(SC));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         pulse_ff <= 1'b0;
      else
         pulse_ff <= state_ff == STC_SEND && cyc_ff < width;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output drivers
   always_ff @(posedge clk)
   begin
      if (rst)
         phase_ff <= 32'h0;
      else
         phase_ff <= phase_ff + STEP;
   end
   assign sine = sine_lut(phase_ff[31:28]);

   always_ff @(posedge clk)
   begin
      if (rst)
         am_ff <= 8'h80;
      else if (!ctrl_ff[`STC_F_AM])
         am_ff <= 8'h80;
      else if (pulse_ff)
         am_ff <= 8'h80 + sine;
      else
         am_ff <= 8'h80 + 8'($signed(sine) >>> 2);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         lvl_ff <= 3'h0;
      else
         lvl_ff <= ctrl_ff[`STC_F_AM] ? 3'h0 : ctrl_ff[6:4] & {3{pulse_ff}};
   end
   assign am_out = am_ff;
   assign lvl_out = lvl_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_fmt_reset: assert property (@(posedge clk) rst |=> ctrl_ff[2:0] == 3'h0)
      else $error("format not basic after reset");
   a_frame_start: assert property (@(posedge clk) disable iff (rst)
      pps_rise |=> state_ff == STC_SEND && idx_ff == 7'h0 ##1 pulse_ff)
      else $error("frame not started on epoch");
   a_zero_end: assert property (@(posedge clk) disable iff (rst)
      state_ff == STC_SEND && !short_ff && !mark_ff[idx_ff] && !data_ff[idx_ff]
      && cyc_ff == L_ZERO && !pps_rise |=> !pulse_ff)
      else $error("zero pulse too long");
   a_mark_pos: assert property (@(posedge clk) disable iff (rst)
      pps_rise && fmt != STC_FMT_W25 |=> mark_ff[59] && mark_ff[69] && mark_ff[79])
      else $error("position marker missing");
   a_parity_odd: assert property (@(posedge clk) disable iff (rst)
      pps_rise && fmt == STC_FMT_STATUS |=> ^data_ff[75:0] && data_ff[78:76] == 3'h0)
      else $error("parity not odd");
   a_qual_never: assert property (@(posedge clk) disable iff (rst)
      !ever_ff |-> qual == 4'hF)
      else $error("unlocked quality not F");
   a_qual_lock: assert property (@(posedge clk) disable iff (rst)
      $past(ref_locked) && ref_locked |-> qual == 4'h0)
      else $error("locked quality not zero");
   a_qual_err: assert property (@(posedge clk) disable iff (rst)
      ever_ff && !ref_locked && err_class == 3'h2 |-> qual == 4'h6)
      else $error("quality error code wrong");
   a_binsec_field: assert property (@(posedge clk) disable iff (rst)
      pps_rise && fmt == STC_FMT_BINSEC |=> {data_ff[97:90], data_ff[88:80]} == $past(day_secs))
      else $error("binary seconds wrong");
   a_leap_flag: assert property (@(posedge clk) disable iff (rst)
      pps_rise && fmt == STC_FMT_STATUS && leap_arm_ff && leap_cnt_ff == 17'd59
      |=> data_ff[60])
      else $error("leap pending not set");
   a_am_excl: assert property (@(posedge clk) disable iff (rst)
      ctrl_ff[`STC_F_AM] |=> lvl_out == 3'h0)
      else $error("level output active with carrier");
endmodule : stc_gen

// ### hdl/stc_pkg.sv
// Types for the serial time code generator
package stc_pkg;
   typedef enum logic [1:0] {STC_IDLE = 2'b01, STC_SEND = 2'b10} stc_state_e;
   typedef enum logic [2:0] {
      STC_FMT_BCD = 3'h0,
      STC_FMT_BINSEC = 3'h1,
      STC_FMT_STATUS = 3'h2,
      STC_FMT_W100 = 3'h3,
      STC_FMT_W25 = 3'h4
   } stc_fmt_e;
endpackage : stc_pkg

// ### verif/stc_reader.sv
// Time code reader model on one level-shift output
module stc_reader
#(
   parameter int BIT_CYC = 40,
   parameter int ZERO_CYC = 8,
   parameter int ONE_CYC = 20,
   parameter int MARK_CYC = 32
)
(
   input wire logic clk,
   input wire logic code_in,
   input wire logic [2:0] scale
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] sym [0:99];
   int npos = 0;
   int nbad = 0;
   int wid = 0;
   int gap = 100000;
   int k;
   int pos;
   logic last = 1'b0;
   logic long_gap = 1'b0;
   logic prev_mark = 1'b0;
   time rise_t = 0;
   time t0 = 0;
   always @(posedge clk)
   begin
      last <= code_in;
      gap <= gap + 1;
      if (code_in)
         wid <= wid + 1;
      if (code_in && !last)
      begin
         long_gap <= gap > 2 * BIT_CYC * scale;
         gap <= 0;
         rise_t <= $time;
         wid <= 1;
      end
      if (!code_in && last)
      begin
         k = 3;
         if (wid == ZERO_CYC * scale)
            k = 0;
         if (wid == ONE_CYC * scale)
            k = 1;
         if (wid == MARK_CYC * scale)
            k = 2;
         if (k == 3)
            nbad <= nbad + 1;
         // frame starts after idle or double marker
         pos = (long_gap || (k == 2 && prev_mark)) ? 0 : npos;
         if (pos < 100)
            sym[pos] <= 2'(k);
         if (pos == 0)
            t0 <= rise_t;
         npos <= pos + 1;
         prev_mark <= k == 2;
      end
   end
endmodule : stc_reader

// ### verif/testbench.sv
// Self-checking bench for the serial time code generator
module testbench
   import stc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic pps_in = 1'b0;
   logic ref_locked = 1'b0;
   logic [2:0] err_class = 3'h0;
   logic [2:0] scale = 3'h1;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] am_out;
   logic [2:0] lvl_out;
   logic [1:0] ef [0:99];
   logic lvl_diff = 1'b0;
   logic lvl_seen = 1'b0;
   logic am_bad = 1'b0;
   logic carrier = 1'b1;
   logic [7:0] am_max = 8'h00;
   logic [31:0] rd;
   logic err;
   time pps_t;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int len;
   int sec, mnt, hr, day, yr, osg, ohr, half, lcnt, ldel, ever, dcnt, dact;
   initial
   begin
      forever #5 clk = ~clk;
   end
   stc_gen #(.BIT_CYC(BIT), .ZERO_CYC(8), .ONE_CYC(20), .MARK_CYC(32)) dut (.clk(clk),
      .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pps_in(pps_in),
      .ref_locked(ref_locked), .err_class(err_class), .am_out(am_out), .lvl_out(lvl_out));
   stc_reader rdr (.clk(clk), .code_in(lvl_out[0]), .scale(scale));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         fails++;
         $display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
      end
   endtask : chk
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (lvl_out[1] !== lvl_out[0] || lvl_out[2] !== lvl_out[0])
         lvl_diff <= 1'b1;
      if (lvl_out !== 3'h0)
         lvl_seen <= 1'b1;
      if (am_out > am_max)
         am_max <= am_out;
      if (!carrier && am_out !== 8'h80)
         am_bad <= 1'b1;
      if (cyc > 90000)
      begin
         fails = fails + 1;
         close_out();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic fire();
      pps_t = $time;
      pps_in <= 1'b1;
      repeat (4) @(posedge clk);
      pps_in <= 1'b0;
   endtask : fire
   task automatic put(input int p, input int v, input int n);
      for (int i = 0; i < n; i++)
         ef[p + i] = 2'((v >> i) & 1);
   endtask : put
   task automatic put_bcd(input int p, input int v, input int tn);
      put(p, v % 10, 4);
      put(p + 5, v / 10, tn);
   endtask : put_bcd
   function automatic int bcd(input int v);
      return v % 10 + 16 * (v / 10);
   endfunction : bcd
   function automatic int qual();
      if (ever == 0)
         return 15;
      if (ref_locked)
         return 0;
      return 4 + ((err_class > 5) ? 5 : err_class);
   endfunction : qual
   // Expected frame from the current time and status
   task automatic build(input stc_fmt_e f);
      int s;
      int ones;
      len = (f == STC_FMT_W25) ? 25 : 100;
      for (int i = 0; i < 100; i++)
         ef[i] = (i == 0 || (f != STC_FMT_W25 && i % 10 == 9)) ? 2'h2 : 2'h0;
      if (f == STC_FMT_W25)
      begin
         put(1, bcd(sec), 7);
         put(8, bcd(mnt), 7);
         put(15, bcd(hr), 6);
         return;
      end
      put_bcd(1, sec, 3);
      put_bcd(10, mnt, 3);
      put_bcd(20, hr, 2);
      put_bcd(30, day % 100, 4);
      put(40, day / 100, 2);
      s = sec + 60 * mnt + 3600 * hr;
      if (f == STC_FMT_BINSEC || f == STC_FMT_STATUS)
      begin
         put(80, s, 9);
         put(90, s >> 9, 8);
      end
      if (f != STC_FMT_STATUS)
         return;
      put_bcd(50, yr, 4);
      ef[60] = 2'(lcnt <= 59);
      ef[61] = 2'(ldel);
      ef[62] = 2'(dcnt == 1);
      ef[63] = 2'(dact);
      put(64, osg + 2 * ohr, 5);
      ef[70] = 2'(half);
      put(71, qual(), 4);
      ones = 0;
      for (int i = 1; i < 75; i++)
         ones += int'(ef[i] == 2'h1);
      ef[75] = 2'(~ones & 1);
   endtask : build
   task automatic wr_time();
      apb(1'b1, 8'h04, {6'h0, 9'(day), 5'(hr), 6'(mnt), 6'(sec)});
   endtask : wr_time
   task automatic prep(input stc_fmt_e f, input logic [6:0] ctrl);
      sec = $urandom_range(59);
      mnt = $urandom_range(59);
      hr = $urandom_range(23);
      day = $urandom_range(366, 1);
      yr = $urandom_range(99);
      osg = $urandom_range(1);
      ohr = $urandom_range(15);
      half = $urandom_range(1);
      ldel = $urandom_range(1);
      lcnt = ($urandom_range(2) == 0) ? 59
           : ($urandom_range(1) ? $urandom_range(58, 2) : $urandom_range(300, 60));
      dcnt = $urandom_range(1) ? 1 : 20;
      dact = $urandom_range(1);
      scale = (f == STC_FMT_W25) ? 3'h4 : 3'h1;
      apb(1'b1, 8'h00, {25'h0, ctrl | 7'(f)});
      wr_time();
      apb(1'b1, 8'h08, {18'h0, 1'(half), 4'(ohr), 1'(osg), 1'h0, 7'(yr)});
      apb(1'b1, 8'h0C, {1'b1, 6'h0, 1'(ldel), 7'h0, 17'(lcnt)});
      apb(1'b1, 8'h10, {1'b1, 5'h0, 1'(dact), 1'b1, 7'h0, 17'(dcnt)});
      carrier = ctrl[3];
      build(f);
   endtask : prep
   task automatic cmp(input int lo, input int hi);
      for (int i = lo; i <= hi && i < len; i++)
         chk(32'(rdr.sym[i]), 32'(ef[i]));
   endtask : cmp
   task automatic finish_frame();
      repeat (len * BIT * scale + 60) @(posedge clk);
      chk(rdr.npos, len);
      chk(rdr.nbad, 0);
      chk((rdr.t0 - pps_t) / 10 inside {[5:7]}, 1);
      cmp(0, 49);
      cmp(50, 58);
      cmp(59, 63);
      cmp(64, 70);
      cmp(71, 74);
      cmp(75, 78);
      cmp(79, 99);
      chk(lvl_diff, 0);
      $display("frame test done, %0d positions", len);
   endtask : finish_frame
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(9));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h8);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[16:12], 5'h0F);
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk(err, 1);
      $display("register test done");
      prep(STC_FMT_BCD, 7'h08);
      fire();
      repeat (4100) @(posedge clk);
      chk(lvl_seen, 0);
      chk(am_max >= 8'hE0, 1);
      $display("carrier test done");
      for (int f = 0; f < 5; f++)
      begin
         prep(stc_fmt_e'(f), 7'h70);
         fire();
         finish_frame();
      end
      ref_locked <= 1'b1;
      ever = 1;
      for (int e = -1; e < 7; e++)
      begin
         if (e >= 0)
            ref_locked <= 1'b0;
         err_class <= (e < 6) ? 3'(e) : 3'($urandom_range(7, 5));
         prep(STC_FMT_STATUS, 7'h70);
         finish_frame_fire();
      end
      prep(STC_FMT_BINSEC, 7'h70);
      fire();
      sec = (sec + 1) % 60;
      wr_time();
      build(STC_FMT_BINSEC);
      while ($time < pps_t + 7960)
         @(posedge clk);
      fire();
      finish_frame();
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[16:12], 5'h19);
      chk(am_bad, 0);
      close_out();
   end
   task automatic finish_frame_fire();
      fire();
      finish_frame();
   endtask : finish_frame_fire
endmodule : testbench
